/* File: design/ltrp_pkg.sv */
/*
 Shared constants of the line thermal replica protection: clock and sample
 rates, model scaling, register offsets, field positions and reset values.
 Assumes a 100 MHz system clock and a 32-bit APB register bus.
*/
package ltrp_pkg;
   localparam int unsigned CLK_HZ = 100_000_000;
   localparam int unsigned SAMPLE_HZ = 1_000;
   localparam int unsigned TICK_DIV = CLK_HZ / SAMPLE_HZ;
   localparam int unsigned STEP_MS = 1_000;
   localparam int unsigned STEP_TICKS = STEP_MS * SAMPLE_HZ / 1_000;
   localparam int unsigned TRIP_PULSE_MS = 100;
   localparam int unsigned TRIP_PULSE_TICKS = TRIP_PULSE_MS * SAMPLE_HZ / 1_000;
   localparam int unsigned RMS_WIN = 20;
   localparam int unsigned MS_PER_MIN = 60_000;
   localparam logic [15:0] CUR_NOM = 16'h03E8;
   localparam logic [7:0] PCT_FULL = 8'h64;
   localparam int unsigned HQ = 16;
   localparam logic [23:0] HEAT_MAX = 24'hFFFFFF;

   localparam logic [1:0] MODE_OFF = 2'h0;
   localparam logic [1:0] MODE_PULSED = 2'h1;
   localparam logic [1:0] MODE_LOCKED = 2'h2;

   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_TEMPS = 8'h04;
   localparam logic [7:0] ADDR_BASE = 8'h08;
   localparam logic [7:0] ADDR_TCONST = 8'h0C;
   localparam logic [7:0] ADDR_STATUS = 8'h10;
   localparam logic [7:0] ADDR_MASK = 8'h14;
   localparam logic [7:0] ADDR_TEMP = 8'h18;
   localparam logic [7:0] ADDR_RMS_A = 8'h1C;
   localparam logic [7:0] ADDR_RMS_B = 8'h20;
   localparam logic [7:0] ADDR_RMS_C = 8'h24;

   localparam int unsigned EV_ALARM = 0;
   localparam int unsigned EV_TRIP = 1;
   localparam int unsigned EV_RELEASE = 2;
   localparam int unsigned EV_W = 3;

   localparam logic [1:0] RST_MODE = MODE_PULSED;
   localparam logic [7:0] RST_ALARM = 8'h50;
   localparam logic [7:0] RST_TRIP = 8'h64;
   localparam logic [7:0] RST_RATED = 8'h64;
   localparam logic [7:0] RST_UNLOCK = 8'h3C;
   localparam logic [7:0] RST_BASE = 8'h19;
   localparam logic [7:0] RST_AMB = 8'h19;
   localparam logic [7:0] RST_START = 8'h00;
   localparam logic [7:0] RST_INOM = 8'h64;
   localparam logic [9:0] RST_TCONST = 10'h00A;
endpackage

/* File: design/ltrp_rms.sv */
/*
 True RMS of one phase current stream: mean of squares over a window of
 samples, then a bit-serial square root. Assumes sample_en pulses far apart
 compared with the sixteen clocks the root needs.
*/
`timescale 1ns/1ps
module ltrp_rms #(
   parameter int unsigned WIN = ltrp_pkg::RMS_WIN
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic sample_en,
   input wire logic signed [15:0] sample,
   output logic [15:0] rms
);
   localparam int unsigned CW = $clog2(WIN + 1);

   if (WIN < 2 || WIN > 65536) begin : g_chk
      $error("ltrp_rms: WIN out of range");
   end

   typedef struct packed {
      logic [47:0] acc;
      logic [CW-1:0] cnt;
      logic [31:0] ms;
      logic [15:0] root;
      logic [3:0] bitn;
      logic busy;
      logic [15:0] rms;
   } ltrp_rms_st_t;

   ltrp_rms_st_t s_q, s_d;
   logic [31:0] sq;
   logic [47:0] sum;
   logic [15:0] trial;

   always_comb begin
      s_d = s_q;
      sq = 32'(sample * sample);
      sum = s_q.acc + 48'(sq);
      trial = s_q.root | (16'h0001 << s_q.bitn);
      if (sample_en) begin
         // Whole window squared and averaged: content below half the sample rate counts
         if (s_q.cnt == CW'(WIN - 1)) begin
            s_d.ms = 32'(sum / 48'(WIN));
            s_d.acc = '0;
            s_d.cnt = '0;
            s_d.root = '0;
            s_d.bitn = 4'hF;
            s_d.busy = 1'b1;
         end else begin
            s_d.acc = sum;
            s_d.cnt = s_q.cnt + CW'(1);
         end
      end else if (s_q.busy) begin
         if (32'(trial * trial) <= s_q.ms) begin
            s_d.root = trial;
         end
         if (s_q.bitn == 4'h0) begin
            s_d.busy = 1'b0;
            s_d.rms = (32'(trial * trial) <= s_q.ms) ? trial : s_q.root;
         end else begin
            s_d.bitn = s_q.bitn - 4'h1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign rms = s_q.rms;
endmodule

/* File: design/ltrp_top.sv */
/*
 Line thermal replica protection: three RMS channels, maximum selection,
 first-order thermal model, threshold decisions and an APB register file.
 Assumes phase samples and user inputs synchronous to clk; samples are taken
 on an internal 1 kHz tick.
 Software keeps the settings in range; out-of-range values are not clipped, except a zero time constant, which is stored as 1.
*/
// Implementation choices: the address map and the APB interface to the registers.
// Summary of operation
// - True RMS per phase over 1 kHz samples, content below 500 Hz kept.
// - Largest of the three RMS values drives the thermal model.
// - Each step: H = H*(1 - dt/T) + dt/T * (I/In)^2.
// - Temperature compared with configured thresholds on every update step unless off or blocked.
// - Trip asserted when temperature rises above trip setting, unless off or blocked.
// - Mode off keeps the alarm, trip and lock outputs low; irq follows the latched status bits.
// - Pulsed mode gives a trip pulse once trip temperature is exceeded.
// - Locked mode holds trip until temperature falls below unlock setting.
// - Block input disables the protection while asserted.
// - Heat reset input reloads the model with the starting value.
// - Sensor select chooses ambient input or fixed ambient setting.
`timescale 1ns/1ps
module ltrp_top #(
   parameter int unsigned TICK_DIV = ltrp_pkg::TICK_DIV,
   parameter int unsigned STEP_TICKS = ltrp_pkg::STEP_TICKS,
   parameter int unsigned PULSE_TICKS = ltrp_pkg::TRIP_PULSE_TICKS
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic signed [15:0] phase_a_current,
   input wire logic signed [15:0] phase_b_current,
   input wire logic signed [15:0] phase_c_current,
   input wire logic signed [7:0] ambient_temp_in,
   input wire logic block_in,
   input wire logic heat_reset_in,
   output logic alarm_out,
   output logic general_trip_out,
   output logic reclose_lock_out,
   output logic irq,
   output logic signed [15:0] computed_temp_value
);
   localparam int unsigned TW = $clog2(TICK_DIV + 1);
   localparam int unsigned SW = $clog2(STEP_TICKS + 1);
   localparam int unsigned PW = $clog2(PULSE_TICKS + 1);

   if (TICK_DIV < 2 || STEP_TICKS < 1 || PULSE_TICKS < 1) begin : g_chk
      $error("ltrp_top: divider, step or pulse count too small");
   end

   typedef enum logic [1:0] {ST_IDLE, ST_DIV, ST_APPLY, ST_CMP} ltrp_state_t;

   typedef struct packed {
      logic [TW-1:0] tick_cnt;
      logic [SW-1:0] step_cnt;
      logic [PW-1:0] pulse_cnt;
      logic [1:0] mode;
      logic sens;
      logic [7:0] alarm_set, trip_set, rated_set, unlock_set;
      logic [7:0] base_set, amb_set, start_set, inom_set;
      logic [9:0] tconst;
      logic [ltrp_pkg::EV_W-1:0] status, mask;
      logic [31:0] prdata;
      logic pready, pslverr;
      logic [23:0] heat;
      ltrp_state_t st;
      logic neg;
      logic [47:0] num;
      logic [47:0] den;
      logic [48:0] rem;
      logic [5:0] bits;
      logic held;
      logic alarm, trip, lock, irq;
      logic signed [15:0] temp;
   } ltrp_top_st_t;

   ltrp_top_st_t s_q, s_d;
   logic tick;
   logic [15:0] rms [3];
   logic signed [15:0] cur [3];
   logic [15:0] imax;
   logic [31:0] i2, in2;
   logic [15:0] in_cnt, kdiv;
   logic [55:0] hp;
   logic signed [49:0] diff;
   logic [48:0] rtry, hsum;
   logic signed [8:0] dtheta;
   logic signed [33:0] rise;
   logic signed [15:0] amb, temp_c;
   logic disabled, over, acc, wr;
   logic [ltrp_pkg::EV_W-1:0] ev;

   // Unaligned or past the last register: refused with pslverr
   function automatic logic addr_ok(input logic [7:0] a);
      addr_ok = (a[1:0] == 2'h0) && (a <= ltrp_pkg::ADDR_RMS_C);
   endfunction

   function automatic logic signed [15:0] deg(input logic [7:0] v);
      deg = signed'({8'h00, v});
   endfunction

   assign cur[0] = phase_a_current;
   assign cur[1] = phase_b_current;
   assign cur[2] = phase_c_current;

   for (genvar p = 0; p < 3; p++) begin : g_rms
      ltrp_rms #(.WIN(ltrp_pkg::RMS_WIN)) u_rms (
         .clk(clk),
         .rst_n(rst_n),
         .sample_en(tick),
         .sample(cur[p]),
         .rms(rms[p])
      );
   end

   always_comb begin
      s_d = s_q;
      ev = '0;
      tick = (s_q.tick_cnt == TW'(TICK_DIV - 1));
      // Largest phase is the heating current
      imax = rms[0];
      if (rms[1] > imax) imax = rms[1];
      if (rms[2] > imax) imax = rms[2];
      i2 = 32'(imax * imax);
      // Rated current setting is a percentage of the nominal count
      in_cnt = 16'((32'(s_q.inom_set) * 32'(ltrp_pkg::CUR_NOM)) / 32'(ltrp_pkg::PCT_FULL));
      in2 = 32'(in_cnt * in_cnt);
      // Steps per time constant; divisor is In^2 times this
      kdiv = 16'((32'(s_q.tconst) * ltrp_pkg::MS_PER_MIN) / ltrp_pkg::STEP_MS);
      hp = 56'(s_q.heat) * 56'(in2);
      // H*In^2*K step: (I^2 - H*In^2) / (In^2*K) added to H
      diff = signed'({2'b00, i2, 16'h0000}) - signed'({1'b0, hp[48:0]});
      rtry = {s_q.rem[47:0], s_q.num[47]};
      hsum = s_q.neg ? (49'(s_q.heat) - 49'(s_q.num)) : (49'(s_q.heat) + 49'(s_q.num));
      // Ambient from sensor input or fixed setting
      amb = s_q.sens ? 16'(ambient_temp_in) : deg(s_q.amb_set);
      dtheta = signed'({1'b0, s_q.rated_set}) - signed'({1'b0, s_q.base_set});
      // Rise above ambient is H scaled by rated minus base
      rise = signed'({10'h000, s_q.heat}) * 34'(dtheta);
      temp_c = amb + 16'(rise >>> ltrp_pkg::HQ);
      // Reserved mode code fails safe as off
      disabled = (s_q.mode != ltrp_pkg::MODE_PULSED && s_q.mode != ltrp_pkg::MODE_LOCKED) || block_in;
      over = temp_c > deg(s_q.trip_set);

      s_d.tick_cnt = tick ? '0 : s_q.tick_cnt + TW'(1);
      if (tick) begin
         s_d.step_cnt = (s_q.step_cnt == SW'(STEP_TICKS - 1)) ? '0 : s_q.step_cnt + SW'(1);
         if (s_q.pulse_cnt != '0) begin
            s_d.pulse_cnt = s_q.pulse_cnt - PW'(1);
            if (s_q.pulse_cnt == PW'(1)) s_d.trip = 1'b0;
         end
      end

      unique case (s_q.st)
         ST_IDLE: begin
            // Uses the last finished RMS, so a current change lags up to one window
            if (tick && s_q.step_cnt == SW'(STEP_TICKS - 1)) begin
               s_d.neg = diff < 0;
               s_d.num = diff < 0 ? 48'(-diff) : 48'(diff);
               s_d.den = 48'(in2) * 48'(kdiv);
               s_d.rem = '0;
               s_d.bits = 6'h2F;
               s_d.st = ST_DIV;
            end
         end
         ST_DIV: begin
            // Restoring division, one quotient bit per clock
            if (rtry >= {1'b0, s_q.den}) begin
               s_d.rem = rtry - {1'b0, s_q.den};
               s_d.num = {s_q.num[46:0], 1'b1};
            end else begin
               s_d.rem = rtry;
               s_d.num = {s_q.num[46:0], 1'b0};
            end
            s_d.bits = s_q.bits - 6'h01;
            if (s_q.bits == 6'h00) s_d.st = ST_APPLY;
         end
         ST_APPLY: begin
            // Saturate rather than wrap: a wrapped heat would read as cold
            if (hsum[48]) s_d.heat = s_q.neg ? 24'h000000 : ltrp_pkg::HEAT_MAX;
            else if (hsum[47:24] != '0) s_d.heat = ltrp_pkg::HEAT_MAX;
            else s_d.heat = hsum[23:0];
            s_d.st = ST_CMP;
         end
         ST_CMP: begin
            s_d.temp = temp_c;
            s_d.st = ST_IDLE;
            if (!disabled) begin
               // Thresholds checked once per model update
               s_d.alarm = temp_c > deg(s_q.alarm_set);
               if (s_d.alarm && !s_q.alarm) ev[ltrp_pkg::EV_ALARM] = 1'b1;
               if (over && !s_q.held) begin
                  s_d.held = 1'b1;
                  s_d.lock = 1'b1;
                  s_d.trip = 1'b1;
                  ev[ltrp_pkg::EV_TRIP] = 1'b1;
                  if (s_q.mode == ltrp_pkg::MODE_PULSED) s_d.pulse_cnt = PW'(PULSE_TICKS);
               end else if (s_q.held && temp_c < deg(s_q.unlock_set)) begin
                  // Release only below unlock temperature
                  s_d.held = 1'b0;
                  s_d.lock = 1'b0;
                  if (s_q.mode == ltrp_pkg::MODE_LOCKED) s_d.trip = 1'b0;
                  ev[ltrp_pkg::EV_RELEASE] = 1'b1;
               end
            end
         end
      endcase

      if (heat_reset_in) begin
         // Drop accumulated heat, restart from startup term
         s_d.heat = 24'((32'(s_q.start_set) << ltrp_pkg::HQ) / 32'(ltrp_pkg::PCT_FULL));
         // Abort a step in flight so its stale quotient is never applied
         s_d.st = ST_IDLE;
      end

      if (disabled) begin
         // Off or blocked: alarm, trip and lock low, latches dropped; status bits kept
         s_d.alarm = 1'b0;
         s_d.trip = 1'b0;
         s_d.lock = 1'b0;
         s_d.held = 1'b0;
         s_d.pulse_cnt = '0;
      end

      acc = psel && penable;
      wr = acc && s_q.pready && pwrite && addr_ok(paddr);
      s_d.pready = acc && !s_q.pready;
      // Error flag stands only in the pready cycle
      s_d.pslverr = 1'b0;
      if (acc && !s_q.pready) begin
         s_d.pslverr = !addr_ok(paddr);
         s_d.prdata = '0;
         unique case (paddr)
            ltrp_pkg::ADDR_CTRL: s_d.prdata = {29'h0, s_q.sens, s_q.mode};
            ltrp_pkg::ADDR_TEMPS: s_d.prdata = {s_q.unlock_set, s_q.rated_set, s_q.trip_set, s_q.alarm_set};
            ltrp_pkg::ADDR_BASE: s_d.prdata = {s_q.inom_set, s_q.start_set, s_q.amb_set, s_q.base_set};
            ltrp_pkg::ADDR_TCONST: s_d.prdata = {22'h0, s_q.tconst};
            ltrp_pkg::ADDR_STATUS: s_d.prdata = {29'h0, s_q.status};
            ltrp_pkg::ADDR_MASK: s_d.prdata = {29'h0, s_q.mask};
            ltrp_pkg::ADDR_TEMP: s_d.prdata = {13'h0, s_q.lock, s_q.trip, s_q.alarm, s_q.temp};
            ltrp_pkg::ADDR_RMS_A: s_d.prdata = {16'h0, rms[0]};
            ltrp_pkg::ADDR_RMS_B: s_d.prdata = {16'h0, rms[1]};
            ltrp_pkg::ADDR_RMS_C: s_d.prdata = {16'h0, rms[2]};
            default: s_d.prdata = '0;
         endcase
      end

      s_d.status = s_q.status;
      if (wr) begin
         unique case (paddr)
            ltrp_pkg::ADDR_CTRL: begin
               s_d.mode = pwdata[1:0];
               s_d.sens = pwdata[2];
            end
            ltrp_pkg::ADDR_TEMPS: {s_d.unlock_set, s_d.rated_set, s_d.trip_set, s_d.alarm_set} = pwdata;
            ltrp_pkg::ADDR_BASE: {s_d.inom_set, s_d.start_set, s_d.amb_set, s_d.base_set} = pwdata;
            // Zero would leave the step divider without a divisor
            ltrp_pkg::ADDR_TCONST: s_d.tconst = (pwdata[9:0] == 10'h000) ? 10'h001 : pwdata[9:0];
            ltrp_pkg::ADDR_STATUS: s_d.status = s_q.status & ~pwdata[ltrp_pkg::EV_W-1:0];
            ltrp_pkg::ADDR_MASK: s_d.mask = pwdata[ltrp_pkg::EV_W-1:0];
            default: s_d.status = s_q.status;
         endcase
      end
      // New event beats a same-cycle clear
      s_d.status = s_d.status | ev;
      s_d.irq = |(s_d.status & s_d.mask);
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s_q <= '0;
         s_q.st <= ST_IDLE;
         s_q.mode <= ltrp_pkg::RST_MODE;
         s_q.alarm_set <= ltrp_pkg::RST_ALARM;
         s_q.trip_set <= ltrp_pkg::RST_TRIP;
         s_q.rated_set <= ltrp_pkg::RST_RATED;
         s_q.unlock_set <= ltrp_pkg::RST_UNLOCK;
         s_q.base_set <= ltrp_pkg::RST_BASE;
         s_q.amb_set <= ltrp_pkg::RST_AMB;
         s_q.start_set <= ltrp_pkg::RST_START;
         s_q.inom_set <= ltrp_pkg::RST_INOM;
         s_q.tconst <= ltrp_pkg::RST_TCONST;
      end else begin
         s_q <= s_d;
      end
   end

   assign prdata = s_q.prdata;
   assign pready = s_q.pready;
   assign pslverr = s_q.pslverr;
   assign alarm_out = s_q.alarm;
   assign general_trip_out = s_q.trip;
   assign reclose_lock_out = s_q.lock;
   assign irq = s_q.irq;
   assign computed_temp_value = s_q.temp;
endmodule

/* File: test/ltrp_front_end.sv */
/*
 Current sampling front end: three phase square waves of set amplitude.
 Assumes amplitudes below 16'h7FFF and a clock shared with the block.
*/
`timescale 1ns/1ps
module ltrp_front_end #(
   parameter int HALF = 40
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [15:0] amp_a,
   input wire logic [15:0] amp_b,
   input wire logic [15:0] amp_c,
   output logic signed [15:0] phase_a_current,
   output logic signed [15:0] phase_b_current,
   output logic signed [15:0] phase_c_current
);
   int cnt_q;
   logic neg_q;
   // Square wave well below half the sample rate, RMS equals amplitude
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cnt_q <= 0;
         neg_q <= 1'b0;
      end else begin
         cnt_q <= (cnt_q == HALF - 1) ? 0 : cnt_q + 1;
         if (cnt_q == HALF - 1) begin
            neg_q <= ~neg_q;
         end
      end
   end
   assign phase_a_current = neg_q ? -$signed(amp_a) : $signed(amp_a);
   assign phase_b_current = neg_q ? -$signed(amp_b) : $signed(amp_b);
   assign phase_c_current = neg_q ? -$signed(amp_c) : $signed(amp_c);
endmodule

/* File: test/ltrp_top_assertions.sv */
/*
 Port checker of the thermal replica block.
 Assumes default alarm 80, trip 100 and unlock 60 degree settings.
*/
`timescale 1ns/1ps
module ltrp_checker (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic block_in,
   input wire logic alarm_out,
   input wire logic general_trip_out,
   input wire logic reclose_lock_out,
   input wire logic signed [15:0] computed_temp_value
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   ready_pulse_a: assert property (pready |=> !pready) else $error("pready longer than one cycle");
   ready_wait_a: assert property (psel && penable && !$past(penable) |-> !pready ##1 pready)
      else $error("pready not after one wait state");
   err_with_ready_a: assert property (pslverr |-> pready) else $error("pslverr without pready");
   err_data_zero_a: assert property (pready && pslverr |-> prdata == 32'h0) else $error("error read not zero");
   block_quiet_a: assert property (block_in |=> !alarm_out && !general_trip_out && !reclose_lock_out)
      else $error("output high while blocked");
   alarm_above_a: assert property ($rose(alarm_out) |-> computed_temp_value > 16'sh0050)
      else $error("alarm below alarm setting");
   trip_above_a: assert property ($rose(general_trip_out) |-> computed_temp_value > 16'sh0064)
      else $error("trip below trip setting");
   lock_with_trip_a: assert property ($rose(general_trip_out) |-> ##[0:2] reclose_lock_out)
      else $error("no lock with trip");
   lock_release_a: assert property ($fell(reclose_lock_out) && !$past(block_in) |-> computed_temp_value < 16'sh003C)
      else $error("lock released above unlock setting");
endmodule

/* File: test/ltrp_top_tb.sv */
/*
 Self-checking bench of the thermal replica block with a front end model.
 Assumes shortened tick, step and pulse counts set below.
*/
`timescale 1ns/1ps
module ltrp_top_tb;
   localparam int TD = 20;
   localparam int ST = 5;
   localparam int PT = 3;
   localparam int STEP_CLK = TD * ST;
   logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, r;
   logic [31:0] prdata;
   logic pready, pslverr, alarm_out, general_trip_out, reclose_lock_out, irq, e, any;
   logic signed [15:0] pa, pb, pc, computed_temp_value;
   logic signed [7:0] ambient_temp_in = 8'sh19;
   logic block_in = 1'b0, heat_reset_in = 1'b0;
   logic [15:0] amp_a = 16'h0000, amp_b = 16'h0000, amp_c = 16'h0000;
   logic [15:0] amps [3];
   logic [31:0] lfsr_q = 32'h0000_9E2A, expv;
   logic [7:0] dflt_a [6] = '{ltrp_pkg::ADDR_CTRL, ltrp_pkg::ADDR_TEMPS, ltrp_pkg::ADDR_BASE,
      ltrp_pkg::ADDR_TCONST, ltrp_pkg::ADDR_STATUS, ltrp_pkg::ADDR_MASK};
   logic [31:0] dflt_v [6] = '{32'h1, 32'h3C64_6450, 32'h6400_1919, 32'h0A, 32'h0, 32'h0};
   int fails = 0, samples_checked = 0, n, w;

   always #5 clk = ~clk;
   ltrp_top #(.TICK_DIV(TD), .STEP_TICKS(ST), .PULSE_TICKS(PT)) dut_u (.clk(clk), .rst_n(rst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .phase_a_current(pa), .phase_b_current(pb), .phase_c_current(pc),
      .ambient_temp_in(ambient_temp_in), .block_in(block_in), .heat_reset_in(heat_reset_in),
      .alarm_out(alarm_out), .general_trip_out(general_trip_out), .reclose_lock_out(reclose_lock_out),
      .irq(irq), .computed_temp_value(computed_temp_value));
   ltrp_front_end #(.HALF(2 * TD)) fe_u (.clk(clk), .rst_n(rst_n), .amp_a(amp_a), .amp_b(amp_b), .amp_c(amp_c),
      .phase_a_current(pa), .phase_b_current(pb), .phase_c_current(pc));

   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // Real-valued replica, steps until temperature passes the trip setting
   function automatic int steps_to_trip(input real ratio, input int tc_min);
      real h;
      int k;
      h = 0.0;
      k = 0;
      while (25.0 + h * 75.0 <= 100.0 && k < 1000) begin
         h = h * (1.0 - 1.0 / (60.0 * tc_min)) + ratio * ratio / (60.0 * tc_min);
         k++;
      end
      return k;
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_near(input logic [31:0] got, input logic [31:0] exp, input int tol);
      samples_checked++;
      if (^got === 1'bx || $signed(got) < $signed(exp) - tol || $signed(got) > $signed(exp) + tol) begin
         fails++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         k++;
      end while (pready !== 1'b1 && k < 100);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (k >= 100) fails++;
   endtask
   task automatic wait_out(input int which, input logic lvl, input int max, output int k);
      logic v;
      k = 0;
      v = ~lvl;
      while (v !== lvl && k < max) begin
         @(negedge clk);
         k++;
         v = (which == 0) ? general_trip_out : (which == 1) ? reclose_lock_out : alarm_out;
      end
      chk({31'h0, v}, {31'h0, lvl});
   endtask
   task automatic set_amps(input logic [15:0] a, input logic [15:0] b, input logic [15:0] c);
      @(posedge clk);
      amp_a <= a;
      amp_b <= b;
      amp_c <= c;
   endtask
   task automatic hreset();
      @(posedge clk);
      heat_reset_in <= 1'b1;
      repeat (3) @(posedge clk);
      heat_reset_in <= 1'b0;
   endtask
   task automatic results();
      if (fails == 0 && samples_checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   initial begin
      repeat (80000) @(posedge clk);
      fails++;
      results();
   end
   initial begin
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 6; i++) begin
         apb(1'b0, dflt_a[i], 32'h0);
         chk(r, dflt_v[i]);
      end
      apb(1'b0, 8'h28, 32'h0);
      chk({31'h0, e}, 32'h1);
      apb(1'b1, 8'h01, 32'hFFFF_FFFF);
      apb(1'b0, ltrp_pkg::ADDR_CTRL, 32'h0);
      chk(r, 32'h1);
      for (int it = 0; it < 2; it++) begin
         for (int j = 0; j < 3; j++) begin
            lfsr_q = lfsr_next(lfsr_q);
            amps[j] = 16'(100 + lfsr_q % 1900);
         end
         ambient_temp_in <= 8'(lfsr_q % 41);
         set_amps(amps[0], amps[1], amps[2]);
         repeat (TD * 50) @(posedge clk);
         for (int j = 0; j < 3; j++) begin
            apb(1'b0, 8'(ltrp_pkg::ADDR_RMS_A + 4 * j), 32'h0);
            chk_near({16'h0, r[15:0]}, {16'h0, amps[j]}, 2);
         end
      end
      apb(1'b1, ltrp_pkg::ADDR_TCONST, 32'h1);
      apb(1'b1, ltrp_pkg::ADDR_MASK, 32'h7);
      // Pulsed mode; phase b carries the largest current
      set_amps(16'h01F4, 16'h09C4, 16'h03E8);
      repeat (600) @(posedge clk);
      apb(1'b1, ltrp_pkg::ADDR_STATUS, 32'h7);
      hreset();
      wait_out(0, 1'b1, 3000, n);
      chk_near(n / STEP_CLK, steps_to_trip(2.5, 1), 1);
      chk({30'h0, alarm_out, reclose_lock_out}, 32'h3);
      wait_out(0, 1'b0, 500, w);
      chk_near(w, PT * TD, TD);
      chk({31'h0, reclose_lock_out}, 32'h1);
      apb(1'b0, ltrp_pkg::ADDR_STATUS, 32'h0);
      chk(r, 32'h3);
      chk({31'h0, irq}, 32'h1);
      apb(1'b1, ltrp_pkg::ADDR_MASK, 32'h0);
      @(negedge clk);
      chk({31'h0, irq}, 32'h0);
      apb(1'b1, ltrp_pkg::ADDR_MASK, 32'h7);
      @(negedge clk);
      chk({31'h0, irq}, 32'h1);
      apb(1'b1, ltrp_pkg::ADDR_STATUS, 32'h3);
      repeat (3) @(posedge clk);
      chk({31'h0, irq}, 32'h0);
      set_amps(16'h0000, 16'h0000, 16'h0000);
      wait_out(1, 1'b0, 15000, n);
      apb(1'b0, ltrp_pkg::ADDR_STATUS, 32'h0);
      chk(r & 32'h4, 32'h4);
      // Locked mode holds trip past the pulse length
      apb(1'b1, ltrp_pkg::ADDR_CTRL, 32'h2);
      set_amps(16'h012C, 16'h0000, 16'h09C4);
      wait_out(0, 1'b1, 4000, n);
      repeat (PT * TD * 3) @(posedge clk);
      chk({31'h0, general_trip_out}, 32'h1);
      block_in <= 1'b1;
      repeat (5) @(posedge clk);
      block_in <= 1'b0;
      // Model kept running under block, so trip returns
      wait_out(0, 1'b1, 300, n);
      @(posedge clk);
      block_in <= 1'b1;
      apb(1'b1, ltrp_pkg::ADDR_CTRL, 32'h0);
      block_in <= 1'b0;
      any = 1'b0;
      repeat (300) begin
         @(negedge clk);
         any = any | alarm_out | general_trip_out | reclose_lock_out;
      end
      chk({31'h0, any}, 32'h0);
      set_amps(16'h0000, 16'h0000, 16'h0000);
      for (int c = 0; c < 2; c++) begin
         lfsr_q = lfsr_next(lfsr_q);
         ambient_temp_in <= 8'(lfsr_q % 41);
         apb(1'b1, ltrp_pkg::ADDR_CTRL, (c == 0) ? 32'h6 : 32'h2);
         if (c == 1) apb(1'b1, ltrp_pkg::ADDR_BASE, 32'h6428_0A19);
         repeat (600) @(posedge clk);
         hreset();
         repeat (STEP_CLK + 60) @(posedge clk);
         expv = (c == 0) ? {{24{ambient_temp_in[7]}}, ambient_temp_in} : 32'd40;
         chk_near({{16{computed_temp_value[15]}}, computed_temp_value}, expv, 1);
         apb(1'b0, ltrp_pkg::ADDR_TEMP, 32'h0);
         chk_near({{16{r[15]}}, r[15:0]}, expv, 1);
         chk({31'h0, general_trip_out}, 32'h0);
      end
      results();
   end
endmodule
bind ltrp_top ltrp_checker chk_u (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .block_in(block_in), .alarm_out(alarm_out),
   .general_trip_out(general_trip_out), .reclose_lock_out(reclose_lock_out),
   .computed_temp_value(computed_temp_value));
